/* File: hdl/level_sync.sv */
// Two-flop synchroniser for slow levels
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	import radio_port_pkg::*;

	logic [WIDTH-1:0] stage1_reg;	// Metastable stage, read only below

	// Two stages on the destination clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1_reg <= '0;
			sync_out   <= '0;
		end else begin
			stage1_reg <= async_in;
			sync_out   <= stage1_reg;
		end
	end
endmodule
`default_nettype wire

/* File: hdl/radio_port_pkg.sv */
// Shared constants and types of the radio serial command port
package radio_port_pkg;

	// ------------------------------------------------------------
	// Command codes and clear-to-send replies
	// ------------------------------------------------------------
	localparam logic [7:0] CODE_POLL        = 8'h44;
	localparam logic [7:0] CODE_FSR_A       = 8'h50;
	localparam logic [7:0] CODE_FSR_B       = 8'h51;
	localparam logic [7:0] CODE_FSR_C       = 8'h53;
	localparam logic [7:0] CODE_FSR_D       = 8'h57;
	localparam logic [7:0] CODE_TX_WRITE    = 8'h66;
	localparam logic [7:0] CODE_RX_READ     = 8'h77;
	localparam logic [7:0] CODE_ALL_STATUS  = 8'h20;
	localparam logic [7:0] CODE_CHIP_STATUS = 8'h23;
	localparam logic [7:0] CTS_READY        = 8'hff;
	localparam logic [7:0] CTS_BUSY         = 8'h00;

	// ------------------------------------------------------------
	// Sizes and field positions
	// ------------------------------------------------------------
	localparam int FIFO_DEPTH = 32'h40;
	localparam int PTR_W      = 32'h6;
	localparam int LVL_W      = 32'h7;
	localparam int RESP_DEPTH = 32'h10;
	localparam int RESP_W     = 32'h4;
	localparam int MAX_PARAMS = 32'hf;
	localparam int FSR_COUNT  = 32'h4;
	localparam int FLAG_W     = 32'h3;
	localparam int FLAG_DONE  = 32'h0;
	localparam int FLAG_ERR   = 32'h1;
	localparam int FLAG_FIFO  = 32'h2;
	localparam int RESP_PEND  = 32'h0;
	localparam int RESP_STAT  = 32'h1;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// Fast status source choices
	localparam logic [1:0] SRC_PEND     = 2'h0;
	localparam logic [1:0] SRC_STAT     = 2'h1;
	localparam logic [1:0] SRC_TX_LEVEL = 2'h2;
	localparam logic [1:0] SRC_RX_LEVEL = 2'h3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CORE_CLK_NS  = 32'h28;
	localparam int PROC_TIME_NS = 32'h280;
	localparam int PROC_CYCLES  = (PROC_TIME_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

	// Kind of the last serial frame
	typedef enum logic [2:0] {
		FRAME_NONE = 3'h0,
		FRAME_CMD  = 3'h1,
		FRAME_POLL = 3'h2,
		FRAME_FSR  = 3'h3,
		FRAME_TXW  = 3'h4,
		FRAME_RXR  = 3'h5
	} frame_kind_t;

endpackage

/* File: hdl/radio_spi_command_port.sv */
// Serial command port: frame decode, command engine, FIFOs, flags
`timescale 1ns/1ps
`default_nettype none
module radio_spi_command_port (
	input  wire logic                                   core_clk,
	input  wire logic                                   rst_n,
	input  wire logic                                   spi_clk,
	input  wire logic                                   chip_select_n,
	input  wire logic                                   spi_mosi,
	output logic                                        spi_miso,
	output logic                                        irq_out_n,
	output logic                                        ready_pin,
	input  wire logic                                   ready_pin_low_when_done,
	input  wire logic [radio_port_pkg::FLAG_W-1:0]      irq_enable,
	input  wire logic [radio_port_pkg::FSR_COUNT-1:0][1:0] fast_status_source_select,
	input  wire logic                                   rx_push,
	input  wire logic [7:0]                             rx_data,
	output logic                                        rx_full,
	input  wire logic                                   tx_pop,
	output logic [7:0]                                  tx_data,
	output logic                                        tx_empty
);
	import radio_port_pkg::*;

	// ------------------------------------------------------------
	// State types
	// ------------------------------------------------------------
	typedef struct packed {
		frame_kind_t                         kind;	// Kind of frame
		logic                                frame_tgl;	// Flips per frame
		logic [7:0]                          code;	// Command code
		logic [MAX_PARAMS-1:0][7:0]          params;	// Parameter bytes
		logic [3:0]                          nparam;	// Parameters taken
		logic [LVL_W-1:0]                    data_cnt;	// FIFO bytes moved
		logic                                err;	// FIFO over/underflow
		logic                                cts_ok;	// Poll saw ready
		logic [RESP_W-1:0]                   resp_ptr;	// Next response byte
		logic [1:0]                          fsr_ptr;	// Next fast register
		logic [7:0]                          tx_hold;	// Next outgoing byte
		logic [FIFO_DEPTH-1:0][7:0]          tx_mem;	// Transmit storage
	} link_state_t;

	typedef struct packed {
		logic                                cs_prev;	// Select seen high
		logic                                frame_seen;	// Last frame taken
		logic                                busy;	// Command running
		logic [4:0]                          proc_cnt;	// Cycles left
		logic [7:0]                          code;	// Running command
		logic [7:0]                          param0;	// Its first parameter
		logic                                has_param;	// Parameter given
		logic [RESP_DEPTH-1:0][7:0]          resp;	// Response buffer
		logic [FLAG_W-1:0]                   pend;	// Latched flags
		logic [PTR_W-1:0]                    tx_wr_ptr;	// Transmit write
		logic [PTR_W-1:0]                    tx_rd_ptr;	// Transmit read
		logic [LVL_W-1:0]                    tx_level;	// Transmit fill
		logic [PTR_W-1:0]                    rx_wr_ptr;	// Receive write
		logic [PTR_W-1:0]                    rx_rd_ptr;	// Receive read
		logic [LVL_W-1:0]                    rx_level;	// Receive fill
		logic [FIFO_DEPTH-1:0][7:0]          rx_mem;	// Receive storage
		logic [FSR_COUNT-1:0][7:0]           fsr;	// Fast status values
		logic                                irq_n;	// Interrupt pin
		logic                                ready;	// Ready pin
		logic                                tx_empty;	// Transmit empty
		logic                                rx_full;	// Receive full
		logic [7:0]                          tx_data;	// Transmit head
	} core_state_t;

	localparam logic [4:0] PROC_LAST = 5'(PROC_CYCLES - 1);
	localparam logic [LVL_W-1:0] DEPTH_LVL = LVL_W'(FIFO_DEPTH);

	link_state_t       link_reg;	// Link-side state
	link_state_t       link_next;	// Its next value
	core_state_t       core_reg;	// Core-side state
	core_state_t       core_next;	// Its next value
	logic              byte_done;	// Byte finished
	logic              first_byte;	// Byte is the code
	logic [7:0]        rx_byte;	// Received byte
	logic              busy_s;	// Busy on link clock
	logic              cs_high_s;	// Select on core clock
	logic              frame_commit;	// New frame ended
	logic [FLAG_W-1:0] cur_flags;	// Current status bits

	// ------------------------------------------------------------
	// Leaves
	// ------------------------------------------------------------
	spi_byte_shifter u_shifter (
		.spi_clk       (spi_clk),
		.chip_select_n (chip_select_n),
		.spi_mosi      (spi_mosi),
		.tx_byte       (link_reg.tx_hold),
		.byte_done     (byte_done),
		.first_byte    (first_byte),
		.rx_byte       (rx_byte),
		.spi_miso      (spi_miso)
	);

	level_sync #(.WIDTH(1)) u_busy_sync (
		.clk      (spi_clk),
		.rst_n    (rst_n),
		.async_in (core_reg.busy),
		.sync_out (busy_s)
	);

	level_sync #(.WIDTH(1)) u_cs_sync (
		.clk      (core_clk),
		.rst_n    (rst_n),
		.async_in (chip_select_n),
		.sync_out (cs_high_s)
	);

	// Start register of a fast status code
	function automatic logic [1:0] fsr_start(input logic [7:0] code);
		logic [1:0] idx;
		idx = 2'h0;
		if (code == CODE_FSR_B) begin
			idx = 2'h1;
		end else if (code == CODE_FSR_C) begin
			idx = 2'h2;
		end else if (code == CODE_FSR_D) begin
			idx = 2'h3;
		end
		return idx;
	endfunction

	// ------------------------------------------------------------
	// Link side: frame decode on the link clock
	// ------------------------------------------------------------
	// Core values read here can also change mid-frame: levels on push or pop, status on completion
	always_comb begin
		logic [LVL_W-1:0] cnt;
		logic [PTR_W-1:0] idx;
		cnt       = '0;
		idx       = '0;
		link_next = link_reg;
		if (byte_done && first_byte) begin
			link_next.frame_tgl = !link_reg.frame_tgl;
			link_next.code      = rx_byte;
			link_next.nparam    = '0;
			link_next.data_cnt  = '0;
			link_next.err       = 1'b0;
			link_next.resp_ptr  = '0;
			link_next.tx_hold   = CTS_BUSY;
			unique case (rx_byte)
				CODE_POLL: begin
					link_next.kind    = FRAME_POLL;
					link_next.cts_ok  = !busy_s;
					link_next.tx_hold = busy_s ? CTS_BUSY : CTS_READY;
				end
				CODE_FSR_A, CODE_FSR_B, CODE_FSR_C, CODE_FSR_D: begin
					link_next.kind    = FRAME_FSR;
					link_next.fsr_ptr = fsr_start(rx_byte) + 2'h1;
					link_next.tx_hold = core_reg.fsr[fsr_start(rx_byte)];
				end
				CODE_TX_WRITE: begin
					link_next.kind = FRAME_TXW;
				end
				CODE_RX_READ: begin
					link_next.kind = FRAME_RXR;
					if (core_reg.rx_level != '0) begin
						link_next.tx_hold = core_reg.rx_mem[core_reg.rx_rd_ptr];
					end
				end
				default: begin
					link_next.kind = FRAME_CMD;
				end
			endcase
		end else if (byte_done) begin
			link_next.tx_hold = CTS_BUSY;
			unique case (link_reg.kind)
				FRAME_CMD: begin
					// Parameters past the fifteenth are dropped
					if (link_reg.nparam != 4'(MAX_PARAMS)) begin
						link_next.params[link_reg.nparam] = rx_byte;
						link_next.nparam = link_reg.nparam + 4'h1;
					end
				end
				FRAME_POLL: begin
					// Response wraps every sixteen bytes
					if (link_reg.cts_ok) begin
						link_next.tx_hold  = core_reg.resp[link_reg.resp_ptr];
						link_next.resp_ptr = link_reg.resp_ptr + 4'h1;
					end
				end
				FRAME_FSR: begin
					link_next.tx_hold = core_reg.fsr[link_reg.fsr_ptr];
					link_next.fsr_ptr = link_reg.fsr_ptr + 2'h1;
				end
				FRAME_TXW: begin
					// Only free slots are written; the rest overflows
					if (link_reg.data_cnt < DEPTH_LVL - core_reg.tx_level) begin
						idx = PTR_W'(core_reg.tx_wr_ptr + link_reg.data_cnt[PTR_W-1:0]);
						link_next.tx_mem[idx] = rx_byte;
						link_next.data_cnt = link_reg.data_cnt + 7'h1;
					end else begin
						link_next.err = 1'b1;
					end
				end
				FRAME_RXR: begin
					// A byte read past the fill level underflows
					if (link_reg.data_cnt < core_reg.rx_level) begin
						cnt = link_reg.data_cnt + 7'h1;
						link_next.data_cnt = cnt;
						idx = PTR_W'(core_reg.rx_rd_ptr + cnt[PTR_W-1:0]);
						if (cnt < core_reg.rx_level) begin
							link_next.tx_hold = core_reg.rx_mem[idx];
						end
					end else begin
						link_next.err = 1'b1;
					end
				end
				default: begin
					link_next.tx_hold = CTS_BUSY;
				end
			endcase
		end
	end

	// Link state register
	always_ff @(posedge spi_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_reg <= '0;
		end else begin
			link_reg <= link_next;
		end
	end

	// ------------------------------------------------------------
	// Core side: command engine, flags and FIFOs
	// ------------------------------------------------------------
	// A frame is taken once select is back high
	assign frame_commit = cs_high_s && !core_reg.cs_prev && (link_reg.frame_tgl != core_reg.frame_seen);

	// Current chip status
	always_comb begin
		cur_flags            = '0;
		cur_flags[FLAG_DONE] = !core_reg.busy;
	end

	// Next core state
	always_comb begin
		logic [FLAG_W-1:0] clr_mask;
		logic [FLAG_W-1:0] set_flags;
		logic [LVL_W-1:0]  tx_add;
		logic [LVL_W-1:0]  tx_sub;
		logic [LVL_W-1:0]  rx_add;
		logic [LVL_W-1:0]  rx_sub;
		clr_mask          = '1;
		set_flags         = '0;
		tx_add            = '0;
		tx_sub            = '0;
		rx_add            = '0;
		rx_sub            = '0;
		core_next         = core_reg;
		core_next.cs_prev = cs_high_s;
		// Completion of the running command
		if (core_reg.busy) begin
			if (core_reg.proc_cnt == '0) begin
				core_next.busy       = 1'b0;
				set_flags[FLAG_DONE] = 1'b1;
				if (core_reg.code == CODE_CHIP_STATUS || core_reg.code == CODE_ALL_STATUS) begin
					core_next.resp[RESP_PEND] = 8'(core_reg.pend);
					core_next.resp[RESP_STAT] = 8'(cur_flags);
					// Zero bits of the parameter clear; none given clears all
					clr_mask = core_reg.has_param ? core_reg.param0[FLAG_W-1:0] : '0;
				end
			end else begin
				core_next.proc_cnt = core_reg.proc_cnt - 5'h1;
			end
		end
		// Frame just ended
		if (frame_commit) begin
			core_next.frame_seen = link_reg.frame_tgl;
			unique case (link_reg.kind)
				FRAME_CMD: begin
					if (core_reg.busy) begin
						set_flags[FLAG_ERR] = 1'b1;
					end else begin
						core_next.busy      = 1'b1;
						core_next.proc_cnt  = PROC_LAST;
						core_next.code      = link_reg.code;
						core_next.param0    = link_reg.params[0];
						core_next.has_param = (link_reg.nparam != '0);
						core_next.resp      = '0;
					end
				end
				FRAME_TXW: begin
					tx_add = link_reg.data_cnt;
					set_flags[FLAG_FIFO] = link_reg.err;
				end
				FRAME_RXR: begin
					rx_sub = link_reg.data_cnt;
					set_flags[FLAG_FIFO] = link_reg.err;
				end
				default: begin
					// Poll and fast reads change no flag; a completion
					// flagged in this same cycle must keep its set
				end
			endcase
		end
		// Drain and fill ports
		if (tx_pop && core_reg.tx_level != '0) begin
			tx_sub = 7'h1;
			core_next.tx_rd_ptr = core_reg.tx_rd_ptr + 6'h1;
		end
		if (rx_push && core_reg.rx_level != DEPTH_LVL) begin
			rx_add = 7'h1;
			core_next.rx_mem[core_reg.rx_wr_ptr] = rx_data;
			core_next.rx_wr_ptr = core_reg.rx_wr_ptr + 6'h1;
		end
		core_next.tx_wr_ptr = core_reg.tx_wr_ptr + tx_add[PTR_W-1:0];
		core_next.rx_rd_ptr = core_reg.rx_rd_ptr + rx_sub[PTR_W-1:0];
		core_next.tx_level  = core_reg.tx_level + tx_add - tx_sub;
		core_next.rx_level  = core_reg.rx_level + rx_add - rx_sub;
		core_next.tx_empty  = (core_next.tx_level == '0);
		core_next.rx_full   = (core_next.rx_level == DEPTH_LVL);
		core_next.tx_data   = link_reg.tx_mem[core_next.tx_rd_ptr];
		// Set wins over clear
		core_next.pend  = (core_reg.pend & clr_mask) | set_flags;
		core_next.irq_n = !(|(core_next.pend & irq_enable));
		core_next.ready = !core_next.busy ^ ready_pin_low_when_done;
		// Fast status sources
		for (int i = 0; i < FSR_COUNT; i++) begin
			unique case (fast_status_source_select[i])
				SRC_PEND:     core_next.fsr[i] = 8'(core_next.pend);
				SRC_STAT:     core_next.fsr[i] = 8'(cur_flags);
				SRC_TX_LEVEL: core_next.fsr[i] = 8'(core_next.tx_level);
				SRC_RX_LEVEL: core_next.fsr[i] = 8'(core_next.rx_level);
			endcase
		end
	end

	// Core state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			core_reg          <= '0;
			core_reg.irq_n    <= 1'b1;
			core_reg.ready    <= 1'b1;
			core_reg.tx_empty <= 1'b1;
		end else begin
			core_reg <= core_next;
		end
	end

	assign irq_out_n = core_reg.irq_n;
	assign ready_pin = core_reg.ready;
	assign tx_data   = core_reg.tx_data;
	assign tx_empty  = core_reg.tx_empty;
	assign rx_full   = core_reg.rx_full;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	busy_status_a: assert property (@(posedge spi_clk) disable iff (!rst_n)
		byte_done && first_byte && rx_byte == CODE_POLL && busy_s |=> link_reg.tx_hold == CTS_BUSY)
		else $error("poll while busy did not answer not-ready");

	busy_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		frame_commit && link_reg.kind == FRAME_CMD && !core_reg.busy |=> core_reg.busy [*8])
		else $error("accepted command ended too early");

	ready_pin_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ready_pin == (!core_reg.busy ^ $past(ready_pin_low_when_done)))
		else $error("ready pin does not match completion");

	done_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(core_reg.busy) |-> core_reg.pend[FLAG_DONE])
		else $error("completion did not set done flag");

	irq_drive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		|(core_reg.pend & $past(irq_enable)) |-> !irq_out_n)
		else $error("enabled pending flag left interrupt high");

	reject_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		frame_commit && link_reg.kind == FRAME_CMD && core_reg.busy
		|=> core_reg.pend[FLAG_ERR] && core_reg.code == $past(core_reg.code))
		else $error("busy command was not rejected");

	resp_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		frame_commit && link_reg.kind == FRAME_CMD && !core_reg.busy |=> core_reg.resp == '0)
		else $error("new command left old response");

	fifo_err_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		frame_commit && link_reg.err && (link_reg.kind == FRAME_TXW || link_reg.kind == FRAME_RXR)
		|=> core_reg.pend[FLAG_FIFO])
		else $error("FIFO error not flagged");

	fsr_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		frame_commit && link_reg.kind == FRAME_FSR && !core_reg.busy |=> core_reg.pend == $past(core_reg.pend))
		else $error("fast status read changed pending flags");

	fifo_bound_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		core_reg.tx_level <= DEPTH_LVL && core_reg.rx_level <= DEPTH_LVL)
		else $error("FIFO level beyond depth");
endmodule
`default_nettype wire

/* File: hdl/spi_byte_shifter.sv */
// Serial byte shifter on the link clock, MSB first
`timescale 1ns/1ps
`default_nettype none
module spi_byte_shifter (
	input  wire logic       spi_clk,
	input  wire logic       chip_select_n,
	input  wire logic       spi_mosi,
	input  wire logic [7:0] tx_byte,
	output logic            byte_done,
	output logic            first_byte,
	output logic [7:0]      rx_byte,
	output logic            spi_miso
);
	import radio_port_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] bit_cnt;	// Bits taken in this byte
		logic [6:0] rx_sh;	// Bits gathered so far
		logic       first;	// Still in the code byte
	} rx_state_t;

	rx_state_t  rx_reg;	// Rising-edge state
	rx_state_t  rx_next;	// Its next value
	logic [7:0] out_reg;	// Falling-edge output shifter

	// Byte completes on the eighth rising edge
	assign byte_done  = (rx_reg.bit_cnt == BIT_LAST);
	assign rx_byte    = {rx_reg.rx_sh, spi_mosi};
	assign first_byte = rx_reg.first;
	assign spi_miso   = out_reg[7];

	// Next rising-edge state
	always_comb begin
		rx_next         = rx_reg;
		rx_next.bit_cnt = rx_reg.bit_cnt + 3'h1;
		rx_next.rx_sh   = {rx_reg.rx_sh[5:0], spi_mosi};
		if (byte_done) begin
			rx_next.first = 1'b0;
		end
	end

	// Chip select high restarts the frame
	always_ff @(posedge spi_clk or posedge chip_select_n) begin
		if (chip_select_n) begin
			rx_reg       <= '0;
			rx_reg.first <= 1'b1;
		end else begin
			rx_reg <= rx_next;
		end
	end

	// Output shifts on falling edges, reloads at byte boundary
	always_ff @(negedge spi_clk or posedge chip_select_n) begin
		if (chip_select_n) begin
			out_reg <= '0;
		end else if (rx_reg.bit_cnt == 3'h0) begin
			out_reg <= tx_byte;
		end else begin
			out_reg <= {out_reg[6:0], 1'b0};
		end
	end
endmodule
`default_nettype wire

/* File: sim/radio_spi_command_port_test.sv */
// Self-checking bench of the radio serial command port
`timescale 1ns/1ps
`default_nettype none
module radio_spi_command_port_test;
	import radio_port_pkg::*;
	typedef struct packed {logic [7:0] code, b1, b2;} row_t;
	logic core_clk = 1'b0, rst_n, spi_clk, chip_select_n, spi_mosi, spi_miso, irq_out_n, ready_pin;
	logic ready_pin_low_when_done, rx_push, tx_pop, rx_full, tx_empty;
	logic [2:0] irq_enable;
	logic [3:0][1:0] fast_status_source_select;
	logic [7:0] rx_data, tx_data;
	int checks = 0, fail_count = 0;
	// Fast reads with three bytes written: A tx, B rx, C pending, D tx
	row_t rows [4] = '{'{8'h50, 8'h03, 8'h00}, '{8'h51, 8'h00, 8'h00}, '{8'h53, 8'h00, 8'h03},
		'{8'h57, 8'h03, 8'h03}};

	always #20 core_clk = ~core_clk;

	spi_host_model host_u (.spi_clk(spi_clk), .chip_select_n(chip_select_n), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso));
	radio_spi_command_port dut_u (.core_clk(core_clk), .rst_n(rst_n), .spi_clk(spi_clk),
		.chip_select_n(chip_select_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .irq_out_n(irq_out_n),
		.ready_pin(ready_pin), .ready_pin_low_when_done(ready_pin_low_when_done), .irq_enable(irq_enable),
		.fast_status_source_select(fast_status_source_select), .rx_push(rx_push), .rx_data(rx_data),
		.rx_full(rx_full), .tx_pop(tx_pop), .tx_data(tx_data), .tx_empty(tx_empty));

	// Byte compare, counted
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Poll until ready, n bytes per frame; bounded
	task automatic poll(input int n);
		for (int k = 0; k < 50; k++) begin
			host_u.tx[0] = CODE_POLL;
			host_u.frame(n);
			if (host_u.rx[1] === CTS_READY) return;
		end
		// Out of tries: counted, the run goes on to the closing report
		fail_count++;
		$display("Error at %0t: poll got %h expected %h", $time, host_u.rx[1], CTS_READY);
	endtask

	task automatic send(input logic [7:0] code, input int n);
		host_u.tx[0] = code;
		host_u.frame(n);
	endtask

	initial begin
		{rst_n, ready_pin_low_when_done, rx_push, tx_pop, rx_data} = '0;
		irq_enable = 3'h7;
		fast_status_source_select = {SRC_TX_LEVEL, SRC_PEND, SRC_RX_LEVEL, SRC_TX_LEVEL};
		repeat (16) @(negedge core_clk);
		chk({4'h0, irq_out_n, ready_pin, tx_empty, rx_full}, 8'h0e);
		rst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		// Three bytes into the transmit queue, then the fast read table
		{host_u.tx[1], host_u.tx[2], host_u.tx[3]} = 24'ha1_5c_3e;
		send(CODE_TX_WRITE, 4);
		foreach (rows[i]) begin
			send(rows[i].code, 3);
			chk(host_u.rx[1], rows[i].b1);
			chk(host_u.rx[2], rows[i].b2);
		end
		for (int i = 1; i < 4; i++) begin
			chk(tx_data, host_u.tx[i]);
			@(negedge core_clk) tx_pop = 1'b1;
			@(negedge core_clk) tx_pop = 1'b0;
		end
		chk({7'h0, tx_empty}, 8'h01);
		// Command, then a second one while busy
		send(8'h01, 1);
		chk({7'h0, ready_pin}, 8'h00);
		send(8'h02, 1);
		chk({7'h0, ready_pin}, 8'h00);
		poll(2);
		chk({6'h0, ready_pin, irq_out_n}, 8'h02);
		send(CODE_FSR_C, 2);
		chk(host_u.rx[1], 8'h03);
		chk({7'h0, irq_out_n}, 8'h00);
		send(CODE_CHIP_STATUS, 1);
		poll(19);
		chk(host_u.rx[2], 8'h03);
		chk(host_u.rx[18], 8'h03);
		poll(3);
		chk(host_u.rx[2], 8'h03);
		send(CODE_FSR_C, 2);
		chk(host_u.rx[1], 8'h01);
		@(negedge core_clk) irq_enable = 3'h6;
		repeat (3) @(negedge core_clk);
		chk({7'h0, irq_out_n}, 8'h01);
		// Fill the receive queue, read one byte too many
		for (int i = 0; i < 64; i++) @(negedge core_clk) {rx_push, rx_data} = {1'b1, 8'(i * 3)};
		@(negedge core_clk) rx_push = 1'b0;
		chk({7'h0, rx_full}, 8'h01);
		send(CODE_RX_READ, 66);
		for (int i = 0; i < 64; i++) chk(host_u.rx[i + 1], 8'(i * 3));
		chk({7'h0, irq_out_n}, 8'h00);
		send(CODE_ALL_STATUS, 1);
		poll(3);
		chk(host_u.rx[2], 8'h05);
		repeat (3) @(negedge core_clk);
		chk({7'h0, irq_out_n}, 8'h01);
		// Sixty-five bytes into an empty transmit queue: one overflows
		send(CODE_TX_WRITE, 66);
		chk({7'h0, irq_out_n}, 8'h00);
		send(CODE_FSR_A, 2);
		chk(host_u.rx[1], 8'h40);
		// Inverted ready polarity while idle drives the pin low
		@(negedge core_clk) ready_pin_low_when_done = 1'b1;
		repeat (2) @(negedge core_clk);
		chk({7'h0, ready_pin}, 8'h00);
		close_out();
	end
endmodule
`default_nettype wire

/* File: sim/spi_host_model.sv */
// Host side serial master model: mode 0 frames, MSB first
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	output logic      spi_clk,
	output logic      chip_select_n,
	output logic      spi_mosi,
	input  wire logic spi_miso
);
	logic [7:0] tx [0:79]; // Bytes to send
	logic [7:0] rx [0:79]; // Bytes seen on the return line

	// Link idles with clock low and select high
	initial begin
		spi_clk = 1'b0;
		chip_select_n = 1'b1;
		spi_mosi = 1'b0;
	end

	// One frame of n bytes; link clock only runs inside it
	task automatic frame(input int n);
		chip_select_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			for (int b = 7; b >= 0; b--) begin
				spi_mosi = tx[i][b];
				#3 spi_clk = 1'b1;
				rx[i][b] = spi_miso;
				#3 spi_clk = 1'b0;
			end
		end
		#3 chip_select_n = 1'b1;
		spi_mosi = ~spi_mosi;
		#200;
	endtask
endmodule
`default_nettype wire
